// *** hprw_pkg.sv ***
// Purpose: Shared constants and types for the host power/reset watchdog block
// Assumes: 250 MHz pclk, APB register access
// Notes:   Pulse lengths in 1/32 s ticks, watchdog in 1 s ticks
package hprw_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned TICK32_HZ       = 32;
  localparam int unsigned TICK32_CYC      = CLK_HZ / TICK32_HZ;
  localparam logic [5:0]  TICKS_PER_SEC   = 6'h20;
  localparam logic [7:0]  HOLD_LONG_T32   = 8'h80;
  localparam logic [7:0]  HOLD_SHORT_T32  = 8'h08;
  localparam logic [7:0]  RST_PULSE_T32   = 8'h20;
  localparam logic [7:0]  PULSE_DEF_T32   = 8'h20;
  localparam logic [7:0]  EXTRA_MAX_T32   = 8'ha0;

  localparam logic [7:0]  EN_RESET_INV    = 8'h02;
  localparam logic [7:0]  EN_POWER_INV    = 8'h04;
  localparam logic [7:0]  STAT_WDOG_ACT   = 8'h08;
  localparam logic [7:0]  EN_BLANK        = 8'h10;
  localparam logic [7:0]  EN_KEY_RESET    = 8'h20;
  localparam logic [7:0]  EN_KEY_PWR_ON   = 8'h40;
  localparam logic [7:0]  EN_KEY_PWR_OFF  = 8'h80;

  localparam logic [7:0]  CMD_PWR_CFG     = 8'h1c;
  localparam logic [7:0]  CMD_WDOG        = 8'h1d;
  localparam logic [7:0]  CMD_STATUS      = 8'h1e;
  localparam logic [7:0]  ACK_FLAG        = 8'h40;
  localparam logic [4:0]  STATUS_LEN      = 5'h0f;

  localparam logic [11:0] ADDR_CMD        = 12'h000;
  localparam logic [11:0] ADDR_REPLY      = 12'h004;
  localparam logic [11:0] ADDR_STAT0      = 12'h008;
  localparam logic [11:0] ADDR_STAT1      = 12'h00c;

  typedef enum logic [2:0] {
    HPRW_IDLE,
    HPRW_RST_PULSE,
    HPRW_ON_PULSE,
    HPRW_OFF_PULSE,
    HPRW_OFF_EXTRA,
    HPRW_SELF_RST
  } hprw_state_type;

  typedef struct packed {
    logic        keep;
    logic        ok;
    logic [31:0] rdata;
  } hprw_apbrsp_type;

  typedef struct packed {
    hprw_state_type state;
    logic [7:0]     en_mask;
    logic [7:0]     pulse_len;
    logic [7:0]     wdog_cnt;
    logic           wdog_act;
    logic [5:0]     sec_div;
    logic [23:0]    pre;
    logic           tick;
    logic [7:0]     hold_t;
    logic [7:0]     run_t;
    logic           sense_d;
    logic           pwr_oe;
    logic           pwr_o;
    logic           rst_oe;
    logic           rst_o;
    logic           blank;
    logic           msg_off;
    logic           self_rst;
    logic [7:0]     reply_type;
    logic [4:0]     reply_len;
    logic           reply_vld;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
  } hprw_state_all_type;
endpackage : hprw_pkg

// *** hprw_top.sv ***
// Purpose: Host power and reset switch controller with host watchdog
// Assumes: Keys and sense already debounced and synchronous to pclk
// Notes:   Commands arrive as APB writes; the reply sits in a register
module hprw_top
  import hprw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_sense,
  input  wire logic        key_cancel,
  input  wire logic        key_confirm,
  output logic             pwr_ctl_o,
  output logic             pwr_ctl_oe,
  output logic             rst_ctl_o,
  output logic             rst_ctl_oe,
  output logic             screen_blank,
  output logic             backlight_off,
  output logic             show_pwr_off,
  output logic             self_reset
);
  import hprw_pkg::*;

  hprw_state_all_type cur_ff;
  hprw_state_all_type nxt_st;
  logic               wr_cmd;
  logic               rd_en;
  logic [7:0]         cmd_type;
  logic [1:0]         cmd_len;
  logic               hold_sense;
  logic               host_dn_blank;

  assign cmd_type      = pwdata[7:0];
  assign cmd_len       = pwdata[9:8];
  assign wr_cmd        = psel && penable && pwrite && (paddr == ADDR_CMD) && !cur_ff.pready;
  assign rd_en         = psel && penable && !pwrite && !cur_ff.pready;
  assign hold_sense    = host_sense;
  assign host_dn_blank = ((cur_ff.en_mask & EN_BLANK) != 8'h00) && !hold_sense;

  always_comb
  begin
    nxt_st = cur_ff;
    nxt_st.tick = 1'b0;
    nxt_st.self_rst = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.sense_d = hold_sense;
    // Free-running 1/32 s prescaler and 1 s divider
    if (cur_ff.pre == 24'(TICK32_CYC - 1))
    begin
      nxt_st.pre = 24'h000000;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.pre = cur_ff.pre + 24'h000001;
    end
    if (cur_ff.tick)
    begin
      nxt_st.sec_div = (cur_ff.sec_div == TICKS_PER_SEC - 6'h01) ? 6'h00 : cur_ff.sec_div + 6'h01;
    end

    // Blanking drives screen_blank and backlight_off; a rising host_sense with EN_BLANK set also pulses self_reset
    nxt_st.blank = host_dn_blank;
    if ((cur_ff.en_mask & EN_BLANK) != 8'h00 && hold_sense && !cur_ff.sense_d)
    begin
      nxt_st.self_rst = 1'b1;
    end

    // Key-hold timer saturates; cleared when no key is held
    if (!key_cancel && !key_confirm)
    begin
      nxt_st.hold_t = 8'h00;
    end
    else if (cur_ff.tick && cur_ff.hold_t != 8'hff)
    begin
      nxt_st.hold_t = cur_ff.hold_t + 8'h01;
    end
    if (cur_ff.tick && cur_ff.run_t != 8'h00)
    begin
      nxt_st.run_t = cur_ff.run_t - 8'h01;
    end

    // Watchdog counts down once a second
    if (cur_ff.wdog_act && cur_ff.tick && cur_ff.sec_div == TICKS_PER_SEC - 6'h01)
    begin
      if (cur_ff.wdog_cnt == 8'h01)
      begin
        nxt_st.wdog_act = 1'b0;
        nxt_st.wdog_cnt = 8'h00;
        if (cur_ff.state == HPRW_IDLE)
        begin
          nxt_st.state = HPRW_RST_PULSE;
          nxt_st.run_t = RST_PULSE_T32;
        end
      end
      else
      begin
        nxt_st.wdog_cnt = cur_ff.wdog_cnt - 8'h01;
      end
    end

    unique case (cur_ff.state)
      HPRW_IDLE:
      begin
        if (hold_sense && key_confirm && (cur_ff.en_mask & EN_KEY_RESET) != 8'h00
            && cur_ff.hold_t >= HOLD_LONG_T32)
        begin
          nxt_st.state = HPRW_RST_PULSE;
          nxt_st.run_t = RST_PULSE_T32;
        end
        else if (!hold_sense && key_confirm && (cur_ff.en_mask & EN_KEY_PWR_ON) != 8'h00
                 && cur_ff.hold_t >= HOLD_SHORT_T32)
        begin
          nxt_st.state = HPRW_ON_PULSE;
          nxt_st.run_t = cur_ff.pulse_len;
        end
        else if (hold_sense && key_cancel && (cur_ff.en_mask & EN_KEY_PWR_OFF) != 8'h00
                 && cur_ff.hold_t >= HOLD_LONG_T32)
        begin
          nxt_st.state = HPRW_OFF_PULSE;
          nxt_st.run_t = cur_ff.pulse_len;
        end
      end
      HPRW_RST_PULSE:
      begin
        if (cur_ff.run_t == 8'h00)
        begin
          nxt_st.state = HPRW_IDLE;
        end
      end
      HPRW_ON_PULSE:
      begin
        if (cur_ff.run_t == 8'h00)
        begin
          nxt_st.state = HPRW_SELF_RST;
        end
      end
      HPRW_OFF_PULSE:
      begin
        if (cur_ff.run_t == 8'h00)
        begin
          nxt_st.state = key_cancel ? HPRW_OFF_EXTRA : HPRW_IDLE;
          nxt_st.run_t = EXTRA_MAX_T32;
        end
      end
      HPRW_OFF_EXTRA:
      begin
        if (!key_cancel || cur_ff.run_t == 8'h00)
        begin
          nxt_st.state = HPRW_IDLE;
        end
      end
      HPRW_SELF_RST:
      begin
        nxt_st.self_rst = 1'b1;
        nxt_st.state = HPRW_IDLE;
      end
      default:
      begin
        nxt_st.state = HPRW_IDLE;
      end
    endcase
    // A reset pulse that finishes with a key still held also reboots the device itself
    if (cur_ff.state == HPRW_RST_PULSE && cur_ff.run_t == 8'h00 && cur_ff.hold_t != 8'h00)
    begin
      nxt_st.self_rst = 1'b1;
    end

    // Line drive: enable only while pulsing, level from invert bits
    nxt_st.rst_oe = (nxt_st.state == HPRW_RST_PULSE);
    nxt_st.rst_o  = (nxt_st.en_mask & EN_RESET_INV) != 8'h00;
    nxt_st.pwr_oe = (nxt_st.state == HPRW_ON_PULSE) || (nxt_st.state == HPRW_OFF_PULSE)
                    || (nxt_st.state == HPRW_OFF_EXTRA);
    nxt_st.pwr_o  = (nxt_st.en_mask & EN_POWER_INV) != 8'h00;
    nxt_st.msg_off = (nxt_st.state == HPRW_OFF_PULSE) || (nxt_st.state == HPRW_OFF_EXTRA);

    // Command decode; one-cycle APB answer
    if (wr_cmd)
    begin
      nxt_st.pready = 1'b1;
      nxt_st.reply_vld = 1'b1;
      nxt_st.reply_type = ACK_FLAG | cmd_type;
      nxt_st.reply_len = 5'h00;
      if (cmd_type == CMD_PWR_CFG && (cmd_len == 2'h1 || cmd_len == 2'h2))
      begin
        nxt_st.en_mask = pwdata[23:16];
        if (cmd_len == 2'h2 && pwdata[31:24] != 8'h00)
        begin
          nxt_st.pulse_len = pwdata[31:24];
        end
      end
      else if (cmd_type == CMD_WDOG && cmd_len == 2'h1)
      begin
        nxt_st.wdog_cnt = pwdata[23:16];
        nxt_st.wdog_act = pwdata[23:16] != 8'h00;
      end
      else if (cmd_type == CMD_STATUS && cmd_len == 2'h0)
      begin
        nxt_st.reply_len = STATUS_LEN;
      end
      else
      begin
        nxt_st.pslverr = 1'b1;
        nxt_st.reply_vld = 1'b0;
      end
    end
    else if (psel && penable && !cur_ff.pready)
    begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h00000000;
      if (rd_en && paddr == ADDR_REPLY)
      begin
        nxt_st.prdata = {15'h0000, cur_ff.reply_vld, 3'h0, cur_ff.reply_len, cur_ff.reply_type};
      end
      else if (rd_en && paddr == ADDR_STAT0)
      begin
        nxt_st.prdata = {16'h0000, cur_ff.wdog_cnt,
                         cur_ff.en_mask | (cur_ff.wdog_act ? STAT_WDOG_ACT : 8'h00)};
      end
      else if (rd_en && paddr == ADDR_STAT1)
      begin
        nxt_st.prdata = {24'h000000, 5'(cur_ff.state), cur_ff.blank, hold_sense, cur_ff.msg_off};
      end
      else
      begin
        nxt_st.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_ff <= '0;
      cur_ff.state <= HPRW_IDLE;
      cur_ff.pulse_len <= PULSE_DEF_T32;
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  assign prdata        = cur_ff.prdata;
  assign pready        = cur_ff.pready;
  assign pslverr       = cur_ff.pslverr;
  assign pwr_ctl_o     = cur_ff.pwr_o;
  assign pwr_ctl_oe    = cur_ff.pwr_oe;
  assign rst_ctl_o     = cur_ff.rst_o;
  assign rst_ctl_oe    = cur_ff.rst_oe;
  assign screen_blank  = cur_ff.blank;
  assign backlight_off = cur_ff.blank;
  assign show_pwr_off  = cur_ff.msg_off;
  assign self_reset    = cur_ff.self_rst;
endmodule : hprw_top

// *** hprw_checker.sv ***
// Purpose: Port assertions for hprw_top
// Assumes: One pclk domain, presetn async active low
// Notes:   Second-scale timers are out of reach here
module hprw_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic host_sense,
  input wire logic pwr_ctl_o,
  input wire logic pwr_ctl_oe,
  input wire logic rst_ctl_oe,
  input wire logic screen_blank,
  input wire logic backlight_off,
  input wire logic show_pwr_off,
  input wire logic self_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] since_ff;
  logic [9:0] nxt_since;
  // Saturates so the counter never wraps into a false window
  assign nxt_since = (since_ff == 10'h3e8) ? since_ff : since_ff + 10'h001;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_ff <= 10'h000;
    else
      since_ff <= nxt_since;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_access; s_wait ##1 pready; endsequence
  property p_answer; s_wait |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("pready late");
  property p_one; s_access |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_pair; screen_blank == backlight_off; endproperty
  a_pair: assert property (p_pair) else $error("blank split");
  property p_lit; host_sense [*3] |-> !screen_blank; endproperty
  a_lit: assert property (p_lit) else $error("blank with host on");
  property p_msg; show_pwr_off |-> pwr_ctl_oe; endproperty
  a_msg: assert property (p_msg) else $error("message undriven");
  property p_hold; pwr_ctl_oe && $past(pwr_ctl_oe) |-> $stable(pwr_ctl_o); endproperty
  a_hold: assert property (p_hold) else $error("power level moved");
  property p_pulse; self_reset |=> !self_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("reboot long");
  property p_boot; $rose(host_sense) && screen_blank |-> ##[1:4] self_reset; endproperty
  a_boot: assert property (p_boot) else $error("no reboot");
  property p_early; since_ff < 10'h3e8 |-> !rst_ctl_oe && !pwr_ctl_oe; endproperty
  a_early: assert property (p_early) else $error("line driven early");
endmodule : hprw_checker

// *** hprw_host_model.sv ***
// Purpose: Host supply and reset lines facing the block
// Assumes: Host lines carry pull-ups
// Notes:   A released line reads the pull-up, never the last drive
module hprw_host_model
(
  input  wire logic host_on,
  input  wire logic pwr_ctl_o,
  input  wire logic pwr_ctl_oe,
  input  wire logic rst_ctl_o,
  input  wire logic rst_ctl_oe,
  output logic      host_sense,
  output logic      pwr_line,
  output logic      rst_line
);
  timeunit 1ns;
  timeprecision 1ps;
  assign host_sense = host_on;
  assign pwr_line   = pwr_ctl_oe ? pwr_ctl_o : 1'b1;
  assign rst_line   = rst_ctl_oe ? rst_ctl_o : 1'b1;
endmodule : hprw_host_model

// *** hprw_bench.sv ***
// Purpose: Self-checking bench for hprw_top
// Assumes: Keys idle; second-scale timers not run
// Notes:   Commands and status go over APB
module hprw_bench
  import hprw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        host_on = 1, key_cancel = 0, key_confirm = 0, err;
  logic [11:0] paddr  = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, host_sense, pwr_ctl_o, pwr_ctl_oe, rst_ctl_o, rst_ctl_oe;
  logic        screen_blank, backlight_off, show_pwr_off, self_reset, pwr_line, rst_line;
  int          failures = 0, checks = 0, cyc = 0;
  always #2 pclk = ~pclk;
  hprw_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .host_sense, .key_cancel, .key_confirm, .pwr_ctl_o, .pwr_ctl_oe, .rst_ctl_o,
    .rst_ctl_oe, .screen_blank, .backlight_off, .show_pwr_off, .self_reset);
  hprw_host_model host_i (.host_on, .pwr_ctl_o, .pwr_ctl_oe, .rst_ctl_o, .rst_ctl_oe,
    .host_sense, .pwr_line, .rst_line);
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      failures++;
      stop_test();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk
  // Request held until the edge that samples pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
    if (n >= 16)
    begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cmd(input logic [7:0] t, input logic [1:0] len, input logic [7:0] d0, input logic [7:0] d1);
    apb(1'b1, ADDR_CMD, {d1, d0, 6'h00, len, t});
  endtask : cmd
  function automatic logic [31:0] ack(input logic [7:0] t, input logic [4:0] len);
    return {15'h0, 1'b1, 3'h0, len, ACK_FLAG | t};
  endfunction : ack
  task stat(input logic [7:0] t, input logic [4:0] len, input logic [7:0] m);
    apb(1'b0, ADDR_REPLY, 32'h0);
    chk("reply", ack(t, len), rd);
    apb(1'b0, ADDR_STAT0, 32'h0);
    chk("mask", {24'h0, m}, {24'h0, rd[7:0]});
  endtask : stat
  task t_cfg;
    logic [7:0] m [6];
    m = '{EN_RESET_INV, EN_POWER_INV, EN_BLANK, EN_KEY_RESET, EN_KEY_PWR_ON, EN_KEY_PWR_OFF};
    foreach (m[i])
    begin
      cmd(CMD_PWR_CFG, 2'h1, m[i], 8'h00);
      stat(CMD_PWR_CFG, 5'h00, m[i]);
    end
    cmd(CMD_PWR_CFG, 2'h2, 8'hf6, 8'h01);
    stat(CMD_PWR_CFG, 5'h00, 8'hf6);
    chk("levels", 32'h3, {30'h0, rst_ctl_o, pwr_ctl_o});
    $display("t_cfg done");
  endtask : t_cfg
  task t_wdog;
    cmd(CMD_WDOG, 2'h1, 8'h05, 8'h00);
    cmd(CMD_WDOG, 2'h1, 8'h05, 8'h00);
    stat(CMD_WDOG, 5'h00, 8'hf6 | STAT_WDOG_ACT);
    chk("count", 32'h5, {24'h0, rd[15:8]});
    cmd(CMD_STATUS, 2'h0, 8'h00, 8'h00);
    stat(CMD_STATUS, STATUS_LEN, 8'hf6 | STAT_WDOG_ACT);
    cmd(CMD_WDOG, 2'h1, 8'h00, 8'h00);
    stat(CMD_WDOG, 5'h00, 8'hf6);
    $display("t_wdog done");
  endtask : t_wdog
  task t_refuse;
    apb(1'b0, 12'h010, 32'h0);
    chk("err_unmapped", 32'h1, {31'h0, err});
    cmd(CMD_PWR_CFG, 2'h3, 8'h20, 8'h01);
    chk("err_len3", 32'h1, {31'h0, err});
    cmd(CMD_PWR_CFG, 2'h0, 8'h20, 8'h01);
    chk("err_len0", 32'h1, {31'h0, err});
    apb(1'b0, ADDR_STAT0, 32'h0);
    chk("mask_kept", 32'hf6, {24'h0, rd[7:0]});
    $display("t_refuse done");
  endtask : t_refuse
  task t_blank;
    int n;
    @(posedge pclk);
    host_on <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("blank", 32'h3, {30'h0, screen_blank, backlight_off});
    host_on <= 1'b1;
    n = 0;
    while (self_reset !== 1'b1 && n < 8)
    begin
      @(posedge pclk);
      n++;
    end
    chk("reboot", 32'h1, {31'h0, self_reset});
    chk("lines", 32'hc, {28'h0, pwr_line, rst_line, pwr_ctl_oe, rst_ctl_oe});
    $display("t_blank done");
  endtask : t_blank
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STAT0, 32'h0);
    chk("stat0_reset", 32'h0, {24'h0, rd[7:0]});
    chk("lines_idle", 32'hc, {28'h0, pwr_line, rst_line, pwr_ctl_oe, rst_ctl_oe});
    t_cfg();
    t_wdog();
    t_refuse();
    t_blank();
    stop_test();
  end
endmodule : hprw_bench
bind hprw_top hprw_checker chk_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .host_sense,
  .pwr_ctl_o, .pwr_ctl_oe, .rst_ctl_oe, .screen_blank, .backlight_off, .show_pwr_off, .self_reset);
